// ---- inc/motion_io_defs.vh ----
`ifndef MOTION_IO_DEFS_VH
`define MOTION_IO_DEFS_VH
// Register offsets (word index = byte address / 4)
`define REG_CTRL        8'h00
`define REG_DATA        8'h04
`define REG_POS         8'h08
`define REG_AREA1       8'h0c
`define REG_AREA2       8'h10
`define REG_STATUS      8'h14
`define REG_IRQ_STAT    8'h18
`define REG_IRQ_MASK    8'h1c
// CTRL fields
`define CTRL_DRIVER     0
`define CTRL_PULSE_SEL  1
`define CTRL_QUAD       2
`define CTRL_STOP_LSB   3
`define CTRL_LOAD_HIT   5
// DATA fields: speed [7:0] mm/s, current [14:8] %, function [17:16], accel [21:20]
`define DATA_SPD_LSB    0
`define DATA_CUR_LSB    8
`define DATA_FN_LSB     16
`define DATA_ACC_LSB    20
`define FN_SINGLE       2'h0
`define FN_LINKED       2'h1
`define FN_PUSH         2'h2
// Stop actions
`define STOP_IMM        2'h0
`define STOP_DEC        2'h1
`define STOP_IMM_OFF    2'h2
`define STOP_DEC_OFF    2'h3
// Limits and timing
`define PUSH_SPD_MAX    8'h19
`define CTRL_RESET      32'h0000_0000
`define DATA_RESET      32'h0000_0006
`define CLK_HZ          25000000
`define FB_LAG_US       1000
`define FB_LAG_CYC      ((`CLK_HZ / 1000000) * `FB_LAG_US)
`define TIM_STEPS       8'h0c
`define DEC_CYC         16'h0040
// Interrupt bits
`define IRQ_ALARM       0
`define IRQ_STOPPED     1
`define IRQ_AREA        2
`endif

// ---- rtl/actuator_motion_io_logic.v ----
// Chosen here: the plain strobed port and the placing of the registers.
`include "motion_io_defs.vh"
`default_nettype none
module actuator_motion_io_logic (
	input  wire        sys_clk_i,
	input  wire        rst_i,
	input  wire [7:0]  addr_i,
	input  wire [31:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [31:0] rdata_o,
	input  wire        jog_positive_in_i,
	input  wire        jog_negative_in_i,
	input  wire        start_i,
	input  wire        stop_i,
	input  wire        homing_i,
	input  wire        homing_halt_in_i,
	input  wire        forward_pulse_in_n_i,
	input  wire        reverse_pulse_in_n_i,
	input  wire        load_contact_i,
	output reg         phase_a_feedback_out_o,
	output reg         phase_b_feedback_out_o,
	output reg         rotor_step_timing_out_o,
	output reg         area_o,
	output reg         torque_reached_o,
	output reg         moving_o,
	output reg         brake_engage_o,
	output reg         motor_current_off_o,
	output reg  [6:0]  current_limit_o,
	output reg  [7:0]  speed_cmd_o,
	output reg  [1:0]  accel_sel_o,
	output reg         bad_operating_data_alarm_o,
	output reg         irq_o
);
	localparam S_IDLE = 3'h0;
	localparam S_POS  = 3'h1;
	localparam S_PUSH = 3'h2;
	localparam S_JOG  = 3'h3;
	localparam S_DEC  = 3'h4;
	localparam S_HOME = 3'h5;

	reg [31:0] ctrl_q;
	reg [31:0] data_q;
	reg [31:0] area1_q;
	reg [31:0] area2_q;
	reg [2:0]  irq_stat_q;
	reg [2:0]  irq_mask_q;
	reg [31:0] pos_q;
	reg [2:0]  state_q;
	reg [15:0] dec_cnt_q;
	reg [31:0] fb_pos_q;
	reg [15:0] lag_cnt_q;
	reg [7:0]  tim_cnt_q;
	reg        push_alarm_q;
	reg        stop_evt_q;
	reg        jog_dir_q;

	wire       driver_mode = ctrl_q[`CTRL_DRIVER];
	wire [1:0] stop_act    = ctrl_q[`CTRL_STOP_LSB+1:`CTRL_STOP_LSB];
	wire [1:0] data_fn     = data_q[`DATA_FN_LSB+1:`DATA_FN_LSB];
	wire [7:0] data_spd    = data_q[`DATA_SPD_LSB+7:`DATA_SPD_LSB];

	function in_window;
		input [31:0] p, a, b;
		begin
			in_window = (a <= b) ? (p >= a && p <= b) : (p >= b && p <= a);
		end
	endfunction

	function [1:0] accel_of;
		input [31:0] d;
		begin
			accel_of = d[`DATA_ACC_LSB+1:`DATA_ACC_LSB];
		end
	endfunction

	// Pulse decode, active-low inputs
	wire       fp_act    = ~forward_pulse_in_n_i;
	wire       rp_act    = ~reverse_pulse_in_n_i;
	wire [1:0] pulse_act = {rp_act, fp_act};
	wire [1:0] pulse_prev;
	wire       fp_prev   = pulse_prev[0];
	wire       rp_prev   = pulse_prev[1];
	reg        step_up;
	reg        step_dn;

	// One history stage per line; reset matches idle level, so no false edge
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_pulse_hist
			reg prev_q;
			always @(posedge sys_clk_i or posedge rst_i) begin
				if (rst_i)
					prev_q <= 1'b0;
				else
					prev_q <= pulse_act[gi];
			end
			assign pulse_prev[gi] = prev_q;
		end
	endgenerate

	always @* begin
		step_up = 1'b0;
		step_dn = 1'b0;
		if (ctrl_q[`CTRL_QUAD]) begin
			// Forward phase leading: an A edge while B opposite
			if (fp_act != fp_prev || rp_act != rp_prev) begin
				if ((fp_act != fp_prev && fp_act != rp_prev) ||
				    (rp_act != rp_prev && rp_act == fp_prev))
					step_up = 1'b1;
				else
					step_dn = 1'b1;
			end
		end else if (ctrl_q[`CTRL_PULSE_SEL]) begin
			// Pulse on forward line, direction on reverse line
			if (fp_act && !fp_prev) begin
				step_up = ~rp_act;
				step_dn = rp_act;
			end
		end else begin
			step_up = fp_act && !fp_prev;
			step_dn = rp_act && !rp_prev;
		end
	end

	wire push_req = (state_q == S_POS) && load_contact_i && (data_fn == `FN_PUSH);
	wire stop_req = driver_mode ? (homing_halt_in_i && state_q == S_HOME) : stop_i;
	// Homing halt may not cut current: upper bit of action dropped
	wire [1:0] eff_act = driver_mode ? {1'b0, stop_act[0]} : stop_act;
	wire jog_any = jog_positive_in_i | jog_negative_in_i;
	wire active = state_q != S_IDLE;
	wire step_tick = active && state_q != S_PUSH && state_q != S_DEC;
	// A held stop blocks restarts; a level stop would otherwise retrigger
	wire hold_off   = driver_mode ? homing_halt_in_i : stop_i;
	wire stop_take  = stop_req && active && state_q != S_DEC;
	wire start_take = !active && !hold_off && (start_i || jog_any || homing_i);

	// Position counter: pulse-driven in driver mode, self-stepping otherwise
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			pos_q <= 32'h0000_0000;
		else if (driver_mode) begin
			if (step_up)
				pos_q <= pos_q + 32'h0000_0001;
			else if (step_dn)
				pos_q <= pos_q - 32'h0000_0001;
		end else if (step_tick) begin
			if ((state_q == S_JOG && jog_dir_q) || state_q == S_HOME)
				pos_q <= pos_q - 32'h0000_0001;
			else
				pos_q <= pos_q + 32'h0000_0001;
		end
	end

	// Current-off stop keeps the brake engaged and current off until the next start
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			motor_current_off_o <= 1'b0;
			brake_engage_o      <= 1'b0;
		end else if (stop_take) begin
			motor_current_off_o <= eff_act[1];
			brake_engage_o      <= eff_act[1];
		end else if (start_take) begin
			motor_current_off_o <= 1'b0;
			brake_engage_o      <= 1'b0;
		end
	end

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q      <= S_IDLE;
			dec_cnt_q    <= 16'h0000;
			push_alarm_q <= 1'b0;
			stop_evt_q   <= 1'b0;
			jog_dir_q    <= 1'b0;
			accel_sel_o  <= 2'h0;
		end else begin
			push_alarm_q <= 1'b0;
			stop_evt_q   <= 1'b0;
			if (stop_take) begin
				stop_evt_q <= 1'b1;
				if (eff_act == `STOP_IMM || eff_act == `STOP_IMM_OFF)
					state_q <= S_IDLE;
				else begin
					state_q   <= S_DEC;
					dec_cnt_q <= `DEC_CYC;
				end
			end else begin
				case (state_q)
				S_IDLE: begin
					if (start_take && homing_i)
						state_q <= S_HOME;
					else if (start_take && !driver_mode && jog_any) begin
						state_q     <= S_JOG;
						jog_dir_q   <= jog_negative_in_i;
						accel_sel_o <= accel_of(data_q);
					end else if (start_take && !driver_mode && start_i) begin
						state_q     <= S_POS;
						accel_sel_o <= accel_of(data_q);
					end
				end
				S_POS: begin
					if (push_req) begin
						if (data_spd > `PUSH_SPD_MAX) begin
							push_alarm_q <= 1'b1;
							state_q      <= S_IDLE;
						end else
							state_q <= S_PUSH;
					end else if (ctrl_q[`CTRL_LOAD_HIT])
						state_q <= S_IDLE;
				end
				S_PUSH:
					if (!load_contact_i)
						state_q <= S_IDLE;
				S_JOG: begin
					// Accel select latched at jog start, only speed follows data
					if (!jog_any) begin
						state_q   <= S_DEC;
						dec_cnt_q <= `DEC_CYC;
					end
				end
				S_DEC: begin
					if (dec_cnt_q == 16'h0000)
						state_q <= S_IDLE;
					else
						dec_cnt_q <= dec_cnt_q - 16'h0001;
				end
				S_HOME:
					if (!homing_i)
						state_q <= S_IDLE;
				default:
					state_q <= S_IDLE;
				endcase
			end
		end
	end

	// Feedback follows position one step per cycle; lag bounded by cycle count
	wire fb_move = fb_pos_q != pos_q;
	wire fb_up   = $signed(pos_q - fb_pos_q) > 0;
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fb_pos_q   <= 32'h0000_0000;
			tim_cnt_q  <= 8'h00;
			phase_a_feedback_out_o  <= 1'b0;
			phase_b_feedback_out_o  <= 1'b0;
			rotor_step_timing_out_o <= 1'b0;
		end else begin
			rotor_step_timing_out_o <= 1'b0;
			if (fb_move) begin
				fb_pos_q  <= fb_up ? fb_pos_q + 32'h0000_0001 : fb_pos_q - 32'h0000_0001;
				// Gray sequence: A leads B when moving positive
				if (fb_up ^ (phase_a_feedback_out_o ^ phase_b_feedback_out_o))
					phase_a_feedback_out_o <= ~phase_a_feedback_out_o;
				else
					phase_b_feedback_out_o <= ~phase_b_feedback_out_o;
				if (tim_cnt_q == `TIM_STEPS - 8'h01) begin
					tim_cnt_q <= 8'h00;
					rotor_step_timing_out_o <= driver_mode;
				end else
					tim_cnt_q <= tim_cnt_q + 8'h01;
			end
		end
	end

	// Lag watch: cycles the feedback trails, saturating at the bound
	wire fb_lag_over = ({16'h0000, lag_cnt_q} >= `FB_LAG_CYC);
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			lag_cnt_q <= 16'h0000;
		else if (!fb_move)
			lag_cnt_q <= 16'h0000;
		else if (!fb_lag_over)
			lag_cnt_q <= lag_cnt_q + 16'h0001;
	end

	// Alarm sticks until cleared; a new alarm wins over the clear
	wire stat_wr = wr_i && addr_i == `REG_IRQ_STAT;
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			bad_operating_data_alarm_o <= 1'b0;
		else if (push_alarm_q)
			bad_operating_data_alarm_o <= 1'b1;
		else if (stat_wr && wdata_i[`IRQ_ALARM])
			bad_operating_data_alarm_o <= 1'b0;
	end

	// Outputs, all registered
	wire [2:0] irq_evt = {area_o == 1'b0 && !driver_mode && in_window(pos_q, area1_q, area2_q),
	                      stop_evt_q, push_alarm_q};
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			area_o           <= 1'b0;
			torque_reached_o <= 1'b0;
			moving_o         <= 1'b0;
			current_limit_o  <= 7'h64;
			speed_cmd_o      <= 8'h00;
			irq_o            <= 1'b0;
		end else begin
			area_o <= !driver_mode && in_window(pos_q, area1_q, area2_q);
			torque_reached_o <= (state_q == S_PUSH);
			moving_o <= active;
			current_limit_o <= (state_q == S_PUSH) ?
				data_q[`DATA_CUR_LSB+6:`DATA_CUR_LSB] : 7'h64;
			speed_cmd_o <= active ? data_spd : 8'h00;
			irq_o <= |(irq_stat_q & irq_mask_q);
		end
	end

	// Register slave
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q     <= `CTRL_RESET;
			data_q     <= `DATA_RESET;
			area1_q    <= 32'h0000_0000;
			area2_q    <= 32'h0000_0000;
			irq_stat_q <= 3'h0;
			irq_mask_q <= 3'h0;
			rdata_o    <= 32'h0000_0000;
		end else begin
			// Set wins over write-one-to-clear
			irq_stat_q <= (irq_stat_q & ~(stat_wr ?
				wdata_i[2:0] : 3'h0)) | irq_evt;
			if (wr_i) begin
				case (addr_i)
				`REG_CTRL:     ctrl_q     <= wdata_i;
				`REG_DATA:     data_q     <= wdata_i;
				`REG_AREA1:    area1_q    <= wdata_i;
				`REG_AREA2:    area2_q    <= wdata_i;
				`REG_IRQ_MASK: irq_mask_q <= wdata_i[2:0];
				default: ;
				endcase
			end
			rdata_o <= 32'h0000_0000;
			if (rd_i) begin
				case (addr_i)
				`REG_CTRL:     rdata_o <= ctrl_q;
				`REG_DATA:     rdata_o <= data_q;
				`REG_POS:      rdata_o <= pos_q;
				`REG_AREA1:    rdata_o <= area1_q;
				`REG_AREA2:    rdata_o <= area2_q;
				`REG_STATUS:   rdata_o <= {24'h00, fb_lag_over, bad_operating_data_alarm_o, area_o,
				                           torque_reached_o, moving_o, state_q};
				`REG_IRQ_STAT: rdata_o <= {29'h0, irq_stat_q};
				`REG_IRQ_MASK: rdata_o <= {29'h0, irq_mask_q};
				default:       rdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/actuator_motion_io_logic_props.sv ----
`default_nettype none
module actuator_motion_io_logic_props (
	input wire logic        sys_clk_i,
	input wire logic        rst_i,
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic        phase_a_feedback_out_o,
	input wire logic        phase_b_feedback_out_o,
	input wire logic        rotor_step_timing_out_o,
	input wire logic        torque_reached_o,
	input wire logic        moving_o,
	input wire logic        brake_engage_o,
	input wire logic        motor_current_off_o,
	input wire logic [7:0]  speed_cmd_o,
	input wire logic        bad_operating_data_alarm_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data standing without a read");
	a_torque_moving: assert property (torque_reached_o |-> moving_o)
		else $error("torque flag outside push state");
	a_brake_pair: assert property (brake_engage_o == motor_current_off_o)
		else $error("brake and current-off disagree");
	a_tim_pulse: assert property (rotor_step_timing_out_o |=> !rotor_step_timing_out_o)
		else $error("timing pulse longer than one cycle");
	a_fb_gray: assert property (!($changed(phase_a_feedback_out_o) &&
		$changed(phase_b_feedback_out_o))) else $error("both feedback phases moved");
	a_alarm_sticky: assert property (bad_operating_data_alarm_o &&
		!(wr_i && addr_i == 8'h18 && wdata_i[0]) |=> bad_operating_data_alarm_o)
		else $error("alarm dropped without clear");
	a_speed_idle: assert property (!moving_o |-> speed_cmd_o == 8'h00)
		else $error("speed commanded while idle");
	a_push_speed: assert property (torque_reached_o |-> speed_cmd_o <= 8'h19)
		else $error("push running above speed limit");
endmodule
`default_nettype wire

// ---- tb/host_pulse_model.sv ----
`default_nettype none
module host_pulse_model (
	input  wire logic sys_clk_i,
	output var logic  forward_pulse_in_n_o,
	output var logic  reverse_pulse_in_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Lines idle high, a pulse is the low level
	initial begin
		forward_pulse_in_n_o = 1'b1;
		reverse_pulse_in_n_o = 1'b1;
	end
	// Four cycles per level, well above the two-cycle minimum
	task automatic hold(input logic f, input logic r);
		@(posedge sys_clk_i);
		forward_pulse_in_n_o <= f;
		reverse_pulse_in_n_o <= r;
		repeat (3) @(posedge sys_clk_i);
	endtask
	// Form 0 two-line, 1 pulse plus direction, 2 quadrature
	task automatic send(input int form, input logic up, input int n);
		if (form == 1) hold(1'b1, up);
		for (int i = 0; i < n; i++) begin
			if (form == 0) begin
				hold(!up, up);
				hold(1'b1, 1'b1);
			end else if (form == 1) begin
				hold(1'b0, up);
				hold(1'b1, up);
			end else begin
				hold(!up, up);
				hold(1'b0, 1'b0);
				hold(up, !up);
				hold(1'b1, 1'b1);
			end
		end
		hold(1'b1, 1'b1);
	endtask
endmodule
`default_nettype wire

// ---- tb/actuator_motion_io_logic_bench.sv ----
`include "motion_io_defs.vh"
`default_nettype none
module actuator_motion_io_logic_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, start_i = 0, stop_i = 0;
	logic        jog_positive_in_i = 0, jog_negative_in_i = 0, homing_i = 0;
	logic        homing_halt_in_i = 0, load_contact_i = 0, a_d = 0, b_d = 0;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0, rd_v;
	wire         forward_pulse_in_n_i, reverse_pulse_in_n_i, phase_a_feedback_out_o, irq_o;
	wire         phase_b_feedback_out_o, rotor_step_timing_out_o, area_o, torque_reached_o;
	wire         moving_o, brake_engage_o, motor_current_off_o, bad_operating_data_alarm_o;
	wire [31:0]  rdata_o;
	wire [6:0]   current_limit_o;
	wire [7:0]   speed_cmd_o;
	wire [1:0]   accel_sel_o;
	int          n_mismatch = 0, checked = 0, n_tim = 0, n_fb = 0, ticks = 0;

	actuator_motion_io_logic actuator_motion_io_logic_inst (.sys_clk_i, .rst_i, .addr_i,
		.wdata_i, .wr_i, .rd_i, .rdata_o, .jog_positive_in_i, .jog_negative_in_i, .start_i,
		.stop_i, .homing_i, .homing_halt_in_i, .forward_pulse_in_n_i, .reverse_pulse_in_n_i,
		.load_contact_i, .phase_a_feedback_out_o, .phase_b_feedback_out_o,
		.rotor_step_timing_out_o, .area_o, .torque_reached_o, .moving_o, .brake_engage_o,
		.motor_current_off_o, .current_limit_o, .speed_cmd_o, .accel_sel_o,
		.bad_operating_data_alarm_o, .irq_o);
	host_pulse_model host_pulse_model_inst (.sys_clk_i,
		.forward_pulse_in_n_o(forward_pulse_in_n_i), .reverse_pulse_in_n_o(reverse_pulse_in_n_i));

	initial forever #20 sys_clk_i = ~sys_clk_i;
	// Run takes a few hundred cycles; the ceiling leaves ample margin
	always @(posedge sys_clk_i) begin
		ticks++;
		n_tim += (rotor_step_timing_out_o === 1'b1);
		n_fb += (phase_a_feedback_out_o !== a_d) + (phase_b_feedback_out_o !== b_d);
		a_d = phase_a_feedback_out_o;
		b_d = phase_b_feedback_out_o;
		if (ticks == 20000) begin
			n_mismatch++;
			close_out;
		end
	end

	task close_out;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1;
		@(posedge sys_clk_i);
		wr_i <= 0;
	endtask
	// Read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1;
		@(posedge sys_clk_i);
		rd_i <= 0;
		#1 rd_v = rdata_o;
	endtask

	task t_regs;
		rd(`REG_CTRL);
		chk("ctrl reset", `CTRL_RESET, rd_v);
		rd(`REG_DATA);
		chk("data reset", `DATA_RESET, rd_v);
		wr(8'h40, 32'hffff_ffff);
		rd(8'h40);
		chk("unmapped read", 32'h0, rd_v);
	endtask
	task t_pulses;
		wr(`REG_CTRL, 32'h1);
		// Slow pulse rate keeps the timing output usable for the host
		host_pulse_model_inst.send(0, 1'b1, 12);
		rd(`REG_POS);
		chk("two-line pos", 32'd12, rd_v);
		chk("feedback steps", 32'd12, n_fb);
		chk("timing pulses", 32'd1, n_tim);
		wr(`REG_CTRL, 32'h3);
		host_pulse_model_inst.send(1, 1'b0, 5);
		rd(`REG_POS);
		chk("pulse-dir pos", 32'd7, rd_v);
		wr(`REG_CTRL, 32'h5);
		host_pulse_model_inst.send(2, 1'b1, 2);
		rd(`REG_POS);
		chk("quad counts up", 32'd15, rd_v);
	endtask
	task push_try(input logic [31:0] d, input logic t, input logic al);
		wr(`REG_DATA, d);
		@(posedge sys_clk_i) start_i <= 1;
		@(posedge sys_clk_i) start_i <= 0;
		load_contact_i <= 1;
		cyc(4);
		chk("torque", {31'd0, t}, {31'd0, torque_reached_o});
		chk("alarm", {31'd0, al}, {31'd0, bad_operating_data_alarm_o});
		if (t) chk("push current", 32'h1e, {25'd0, current_limit_o});
		@(posedge sys_clk_i) load_contact_i <= 0;
		stop_i <= 1;
		@(posedge sys_clk_i) stop_i <= 0;
		cyc(3);
	endtask
	task t_push;
		wr(`REG_CTRL, 32'h0);
		push_try(32'h0000_1e06, 0, 0);
		push_try(32'h0002_1e19, 1, 0);
		push_try(32'h0002_1e1a, 0, 1);
		chk("irq masked", 32'h0, {31'd0, irq_o});
		wr(`REG_IRQ_MASK, 32'h1);
		cyc(2);
		chk("irq raised", 32'h1, {31'd0, irq_o});
		wr(`REG_IRQ_STAT, 32'h1);
		cyc(2);
		chk("alarm cleared", 32'h0, {31'd0, bad_operating_data_alarm_o});
		chk("irq cleared", 32'h0, {31'd0, irq_o});
	endtask
	task t_jog;
		wr(`REG_CTRL, 32'h10);
		wr(`REG_DATA, 32'h0000_0014);
		@(posedge sys_clk_i) jog_positive_in_i <= 1;
		cyc(3);
		chk("jog moving", 32'h1, {31'd0, moving_o});
		chk("jog speed", 32'h14, {24'd0, speed_cmd_o});
		wr(`REG_DATA, 32'h0030_000a);
		cyc(2);
		chk("jog new speed", 32'h0a, {24'd0, speed_cmd_o});
		chk("jog accel kept", 32'h0, {30'd0, accel_sel_o});
		@(posedge sys_clk_i) stop_i <= 1;
		cyc(3);
		chk("stopped", 32'h0, {31'd0, moving_o});
		chk("brake on", 32'h1, {31'd0, brake_engage_o});
		chk("current off", 32'h1, {31'd0, motor_current_off_o});
		@(posedge sys_clk_i) stop_i <= 0;
		jog_positive_in_i <= 0;
		@(posedge sys_clk_i) jog_negative_in_i <= 1;
		cyc(3);
		chk("reverse jog", 32'h1, {31'd0, moving_o});
		chk("brake freed", 32'h0, {31'd0, brake_engage_o});
		@(posedge sys_clk_i) jog_negative_in_i <= 0;
		cyc(70);
	endtask
	// Current-off decel selected, homing halt must fall back to plain decel
	task t_halt;
		wr(`REG_CTRL, 32'h19);
		@(posedge sys_clk_i) homing_i <= 1;
		cyc(3);
		@(posedge sys_clk_i) homing_halt_in_i <= 1;
		cyc(2);
		chk("decelerating", 32'h1, {31'd0, moving_o});
		cyc(70);
		chk("halted", 32'h0, {31'd0, moving_o});
		chk("no current-off", 32'h0, {31'd0, motor_current_off_o});
		@(posedge sys_clk_i) homing_halt_in_i <= 0;
		homing_i <= 0;
	endtask
	// Bounds kept apart: a single-point window is never relied on
	task t_area;
		wr(`REG_CTRL, 32'h0);
		wr(`REG_AREA1, 32'h0);
		wr(`REG_AREA2, 32'hffff_ffff);
		cyc(2);
		chk("area inside", 32'h1, {31'd0, area_o});
		wr(`REG_AREA1, 32'hffff_0000);
		cyc(2);
		chk("area outside", 32'h0, {31'd0, area_o});
		wr(`REG_AREA1, 32'h0);
		wr(`REG_CTRL, 32'h1);
		cyc(2);
		chk("area driver mode", 32'h0, {31'd0, area_o});
	endtask

	initial begin
		repeat (12) @(posedge sys_clk_i);
		rst_i <= 0;
		t_regs;
		t_pulses;
		t_push;
		t_jog;
		t_halt;
		t_area;
		close_out;
	end
endmodule
bind actuator_motion_io_logic actuator_motion_io_logic_props props_inst (.sys_clk_i, .rst_i,
	.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .phase_a_feedback_out_o,
	.phase_b_feedback_out_o, .rotor_step_timing_out_o, .torque_reached_o, .moving_o,
	.brake_engage_o, .motor_current_off_o, .speed_cmd_o, .bad_operating_data_alarm_o);
`default_nettype wire
